// ==== core/beat_buffer.v ====
// small beat memory holding burst write data
`default_nettype none
module beat_buffer #(
	parameter DW = 32,
	parameter AW = 2
)(
	// clock
	input  wire          ref_clk,
	// write port
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [DW-1:0] wr_data,
	// read port
	input  wire [AW-1:0] rd_addr,
	output reg  [DW-1:0] rd_data_ff
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge ref_clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data_ff <= mem[rd_addr];
	end
endmodule // beat_buffer
`default_nettype wire

// ==== core/data_beat_termination.v ====
// data beat termination logic of the bus master, with APB register access
// Summary of operation
// - each beat terminated; burst ends on last
// - ack completes beat unless retry follows
// - hold write data or wait while unacked
// - retry discards previously accepted read data
// - retry ignored on writes and direct-store
// - retry sampled at reset selects no-retry mode
// - bus error raises machine check or checkstop
// - bus error ends tenure, ack/retry ignored
// - busy negated and floated next clock
// - direct-store errors deferred to last tenure
// - streaming ignores error clock after read ack
// - float write data after final ack
`default_nettype none
`include "beat_term_defs.vh"
module data_beat_termination #(
	parameter DW = 32
)(
	// clock and reset
	input  wire          ref_clk,
	input  wire          rst_n,
	// apb slave
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [11:0]   paddr,
	input  wire [31:0]   pwdata,
	output reg  [31:0]   prdata_ff,
	output reg           pready_ff,
	output reg           pslverr_ff,
	// termination inputs from the system
	input  wire          beat_ack_n,
	input  wire          late_read_retry_n,
	input  wire          bus_error_ack_n,
	// data bus
	input  wire [DW-1:0] data_in,
	output reg  [DW-1:0] data_out_ff,
	output reg           data_oe_ff,
	output reg           data_bus_busy_n_out_ff,
	output reg           data_bus_busy_oe_ff,
	// exception outputs
	output reg           machine_check_ff,
	output reg           checkstop_ff
);
	localparam IDLE = 2'd0;
	localparam DATA = 2'd1;
	localparam RCHK = 2'd2;

	reg [1:0]  state_ff, nxt_state;
	reg [1:0]  ctrl_ff;
	reg        no_retry_ff, strap_done_ff;
	reg        rd_ff, burst_ff, dstore_ff, last_ff;
	reg [1:0]  beat_ff;
	reg [2:0]  beats_done_ff;
	reg        done_ff, retry_ff, berr_ff, pend_ff;
	reg [31:0] rdata_ff;
	reg        ack_dly_ff;
	reg        wbuf_we;
	reg [1:0]  wbuf_ptr_ff;
	wire [DW-1:0] wbuf_q;

	wire ack   = ~beat_ack_n;
	wire retry = ~late_read_retry_n;
	wire berr  = ~bus_error_ack_n;
	wire acc   = psel & penable & pready_ff;
	wire wr    = acc & pwrite;
	wire start = wr && paddr == `REG_CMD && state_ff == IDLE && !checkstop_ff;
	wire last_beat = !burst_ff || {30'h0, beat_ff} == `BURST_BEATS - 1;
	// buffer read runs one beat ahead so the next word is ready at each ack
	wire [1:0] wbuf_rd_ptr = (state_ff == DATA) ? beat_ff + 2'h1 : 2'h0;
	// error not seen in the slot after a streaming read ack
	wire berr_ok = berr && !(ctrl_ff[`CTRL_STREAM_BIT] && rd_ff && ack_dly_ff);
	wire retry_ok = retry && rd_ff && !dstore_ff && !no_retry_ff;

	beat_buffer #(.DW(DW), .AW(2)) u_buf (
		.ref_clk (ref_clk),
		.wr_en   (wbuf_we),
		.wr_addr (wbuf_ptr_ff),
		.wr_data (pwdata[DW-1:0]),
		.rd_addr (wbuf_rd_ptr),
		.rd_data_ff (wbuf_q)
	);

	always @*
	begin
		wbuf_we = wr && paddr == `REG_WDATA;
	end

	always @*
	begin
		nxt_state = state_ff;
		case (state_ff)
			IDLE:
				if (start)
					nxt_state = DATA;
			DATA:
				if (berr_ok)
					nxt_state = IDLE;
				else if (ack && last_beat)
					nxt_state = (rd_ff && !no_retry_ff && !dstore_ff) ? RCHK : IDLE;
			RCHK:
				if (berr_ok)
					nxt_state = IDLE;
				else if (!retry)
					nxt_state = IDLE;
			default:
				nxt_state = IDLE;
		endcase
	end

	// apb side and register file
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready_ff   <= 1'b0;
			pslverr_ff  <= 1'b0;
			prdata_ff   <= 32'h0000_0000;
			ctrl_ff     <= `CTRL_RESET;
			wbuf_ptr_ff <= 2'h0;
		end
		else
		begin
			pready_ff  <= psel & ~pready_ff;
			pslverr_ff <= 1'b0;
			if (psel && !pready_ff)
			begin
				if (paddr == `REG_CTRL)
					prdata_ff <= {30'h0, ctrl_ff};
				else if (paddr == `REG_STATUS)
					prdata_ff <= {24'h0, pend_ff, no_retry_ff, checkstop_ff, machine_check_ff,
						berr_ff, retry_ff, done_ff, state_ff != IDLE};
				else if (paddr == `REG_RDATA)
					prdata_ff <= rdata_ff;
				else if (paddr == `REG_BEATS)
					prdata_ff <= {29'h0, beats_done_ff};
				else if (paddr == `REG_CMD || paddr == `REG_WDATA)
					prdata_ff <= 32'h0000_0000;
				else
				begin
					prdata_ff  <= 32'h0000_0000;
					pslverr_ff <= 1'b1;
				end
			end
			if (wr && paddr == `REG_CTRL)
				ctrl_ff <= pwdata[1:0];
			if (wbuf_we)
				wbuf_ptr_ff <= wbuf_ptr_ff + 2'h1;
			else if (start)
				wbuf_ptr_ff <= 2'h0;
		end
	end

	// mode strap caught on the first clock after reset release
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strap_done_ff <= 1'b0;
			no_retry_ff   <= 1'b0;
		end
		else if (!strap_done_ff)
		begin
			strap_done_ff <= 1'b1;
			no_retry_ff   <= retry;
		end
	end

	// beat engine
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff      <= IDLE;
			rd_ff         <= 1'b0;
			burst_ff      <= 1'b0;
			dstore_ff     <= 1'b0;
			last_ff       <= 1'b0;
			beat_ff       <= 2'h0;
			beats_done_ff <= 3'h0;
			done_ff       <= 1'b0;
			retry_ff      <= 1'b0;
			berr_ff       <= 1'b0;
			pend_ff       <= 1'b0;
			rdata_ff      <= 32'h0000_0000;
			ack_dly_ff    <= 1'b0;
			data_out_ff   <= {DW{1'b0}};
			data_oe_ff    <= 1'b0;
			data_bus_busy_n_out_ff <= 1'b1;
			data_bus_busy_oe_ff    <= 1'b0;
			machine_check_ff <= 1'b0;
			checkstop_ff  <= 1'b0;
		end
		else
		begin
			state_ff   <= nxt_state;
			ack_dly_ff <= state_ff == DATA && ack && rd_ff;
			if (start)
			begin
				rd_ff         <= pwdata[`CMD_READ_BIT];
				burst_ff      <= pwdata[`CMD_BURST_BIT];
				dstore_ff     <= pwdata[`CMD_DSTORE_BIT];
				last_ff       <= pwdata[`CMD_LAST_BIT];
				beat_ff       <= 2'h0;
				beats_done_ff <= 3'h0;
				done_ff       <= 1'b0;
				retry_ff      <= 1'b0;
				data_bus_busy_n_out_ff <= 1'b0;
				data_bus_busy_oe_ff    <= 1'b1;
				data_oe_ff    <= !pwdata[`CMD_READ_BIT];
				data_out_ff   <= wbuf_q;
			end
			if (wr && paddr == `REG_STATUS && pwdata[`ST_BERR_BIT])
				berr_ff <= 1'b0;
			if (wr && paddr == `REG_STATUS && pwdata[`ST_MCHK_BIT])
				machine_check_ff <= 1'b0;
			// write data held while no ack, advanced after each ack but the last
			if (state_ff == DATA && !rd_ff && ack && !berr_ok && !last_beat)
				data_out_ff <= wbuf_q;
			if (state_ff == DATA && berr_ok)
			begin
				// terminate tenure, release busy next clock
				data_bus_busy_n_out_ff <= 1'b1;
				data_bus_busy_oe_ff    <= 1'b0;
				data_oe_ff    <= 1'b0;
				berr_ff       <= 1'b1;
				if (dstore_ff && !last_ff)
					pend_ff <= 1'b1;
				else if (ctrl_ff[`CTRL_MCE_BIT])
					machine_check_ff <= 1'b1;
				else
					checkstop_ff <= 1'b1;
				if (dstore_ff && last_ff)
					pend_ff <= 1'b0;
			end
			else if (state_ff == RCHK && berr_ok)
			begin
				berr_ff <= 1'b1;
				if (ctrl_ff[`CTRL_MCE_BIT])
					machine_check_ff <= 1'b1;
				else
					checkstop_ff <= 1'b1;
			end
			else if (state_ff == DATA && ack)
			begin
				if (rd_ff)
					rdata_ff <= data_in[31:0];
				beat_ff       <= beat_ff + 2'h1;
				beats_done_ff <= beats_done_ff + 3'h1;
				if (last_beat)
				begin
					data_bus_busy_n_out_ff <= 1'b1;
					data_bus_busy_oe_ff    <= 1'b0;
					data_oe_ff    <= 1'b0;
					if (nxt_state == IDLE)
						done_ff <= 1'b1;
				end
				if (dstore_ff && last_ff && pend_ff)
				begin
					pend_ff <= 1'b0;
					if (ctrl_ff[`CTRL_MCE_BIT])
						machine_check_ff <= 1'b1;
					else
						checkstop_ff <= 1'b1;
				end
			end
			else if (state_ff == RCHK)
			begin
				if (retry_ok)
				begin
					// speculative data withdrawn, beat count taken back
					retry_ff      <= 1'b1;
					rdata_ff      <= 32'h0000_0000;
					beats_done_ff <= beats_done_ff - 3'h1;
				end
				else
					done_ff <= 1'b1;
			end
		end
	end
endmodule // data_beat_termination
`default_nettype wire

// ==== shared/beat_term_defs.vh ====
// constants for the data beat termination block
`ifndef BEAT_TERM_DEFS_VH
`define BEAT_TERM_DEFS_VH
// register byte offsets
`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define REG_CMD         12'h008
`define REG_WDATA       12'h00C
`define REG_RDATA       12'h010
`define REG_BEATS       12'h014
// control fields
`define CTRL_MCE_BIT    0
`define CTRL_STREAM_BIT 1
`define CTRL_RESET      2'h1
// command fields
`define CMD_READ_BIT    0
`define CMD_BURST_BIT   1
`define CMD_DSTORE_BIT  2
`define CMD_LAST_BIT    3
// status fields
`define ST_BUSY_BIT     0
`define ST_DONE_BIT     1
`define ST_RETRY_BIT    2
`define ST_BERR_BIT     3
`define ST_MCHK_BIT     4
`define ST_CKSTOP_BIT   5
`define ST_NODRTRY_BIT  6
`define ST_PEND_BIT     7
// beats per burst
`define BURST_BEATS     4
`endif

// ==== sim/beat_term_props.sv ====
// concurrent checks on the beat termination block ports
`default_nettype none
module beat_term_props #(
	parameter DW = 32
)(
	// clock, reset and apb
	input wire logic          ref_clk, rst_n, psel, penable, pready_ff,
	// termination inputs
	input wire logic          beat_ack_n, bus_error_ack_n,
	// data bus and flags
	input wire logic          data_oe_ff, data_bus_busy_n_out_ff, data_bus_busy_oe_ff,
	input wire logic [DW-1:0] data_out_ff,
	input wire logic          machine_check_ff, checkstop_ff
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_err_hit;
		!bus_error_ack_n && !data_bus_busy_n_out_ff && $past(beat_ack_n);
	endsequence
	sequence s_released;
		!data_bus_busy_oe_ff;
	endsequence
	a_err_bus_release: assert property (s_err_hit |-> ##[1:2] s_released)
		else $error("busy kept after bus error");
	a_pready_one: assert property (pready_ff |=> !pready_ff)
		else $error("pready longer than one cycle");
	a_apb_answer: assert property (psel && !penable |-> ##[1:3] pready_ff)
		else $error("apb transfer not answered");
	a_wdata_hold: assert property (data_oe_ff && beat_ack_n && bus_error_ack_n |=> data_oe_ff && $stable(data_out_ff))
		else $error("write data moved without ack");
	a_float_cause: assert property ($fell(data_oe_ff) |-> !$past(beat_ack_n) || !$past(bus_error_ack_n))
		else $error("data floated without termination");
	a_oe_in_tenure: assert property (data_oe_ff |-> !data_bus_busy_n_out_ff)
		else $error("data driven outside tenure");
	a_busy_driven: assert property (!data_bus_busy_n_out_ff |-> data_bus_busy_oe_ff)
		else $error("busy asserted but not driven");
	a_mchk_cause: assert property ($rose(machine_check_ff) |-> !$past(bus_error_ack_n) || !$past(bus_error_ack_n, 2))
		else $error("machine check without bus error");
	a_ckstop_cause: assert property ($rose(checkstop_ff) |-> !$past(bus_error_ack_n) || !$past(bus_error_ack_n, 2))
		else $error("checkstop without bus error");
endmodule // beat_term_props
bind data_beat_termination beat_term_props #(.DW(DW)) u_beat_term_props (.*);
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench for the beat termination block
`default_nettype none
`include "beat_term_defs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata_ff, data_in, data_out_ff, rd_word = 32'h0;
	logic pready_ff, pslverr_ff, beat_ack_n, late_read_retry_n, bus_error_ack_n;
	logic data_oe_ff, data_bus_busy_n_out_ff, data_bus_busy_oe_ff, machine_check_ff, checkstop_ff;
	logic rty_en = 0, err_en = 0, strap_n = 1, busy_w;
	logic [1:0] wt = 2'h1;
	logic [32:0] eq[$], e;
	logic [31:0] mq[$], wq[$], m;
	int n_fail = 0, checks = 0, i;
	assign busy_w = data_bus_busy_oe_ff ? data_bus_busy_n_out_ff : 1'b1;
	always #50 ref_clk = ~ref_clk;
	data_beat_termination u_data_beat_termination (.*);
	term_partner u_term_partner (.ref_clk, .rst_n, .busy_n(busy_w), .rty_en, .err_en, .strap_n, .wt,
		.rd_word, .beat_ack_n, .late_read_retry_n, .bus_error_ack_n, .data_in);
	task cmp(input logic [32:0] g, x);
		checks++;
		if (g !== x)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, g, x);
		end
	endtask
	task give_verdict;
		if (eq.size() || wq.size())
			n_fail++;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready_ff !== 1'b1);
		{psel, penable} <= 2'b00;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] x, k);
		eq.push_back({a > 12'h014, x});
		mq.push_back(k);
		apb(1'b0, a, 32'h0);
	endtask
	task go(input logic [3:0] c, input int n);
		logic [31:0] d;
		wt <= 2'(1 + $urandom % 3);
		rd_word <= $urandom;
		repeat (n)
		begin
			d = $urandom;
			apb(1'b1, `REG_WDATA, d);
			if (!c[0] && !err_en)
				wq.push_back(d);
		end
		apb(1'b1, `REG_CMD, {28'h0, c});
		repeat (2) @(posedge ref_clk);
		while (data_bus_busy_oe_ff !== 1'b0) @(posedge ref_clk);
		repeat (3) @(posedge ref_clk);
	endtask
	always @(posedge ref_clk)
	begin
		if (psel && penable && pready_ff === 1'b1 && !pwrite)
		begin
			e = eq.pop_front();
			m = mq.pop_front();
			cmp({pslverr_ff, prdata_ff & m}, {e[32], e[31:0] & m});
		end
		if (beat_ack_n === 1'b0 && data_oe_ff === 1'b1)
			cmp({1'b0, data_out_ff}, {1'b0, wq.size() ? wq.pop_front() : ~data_out_ff});
	end
	initial
	begin
		#1000000;
		n_fail++;
		give_verdict;
	end
	initial
	begin
		void'($urandom(32'h02B9035A));
		for (i = 0; i < 2; i++)
		begin
			rst_n <= 1'b0;
			strap_n <= 1'(i);
			repeat (8) @(posedge ref_clk);
			rst_n <= 1'b1;
			repeat (2) @(posedge ref_clk);
			strap_n <= 1'b1;
			rd(`REG_STATUS, {!i, 6'h0}, 32'h40);
			rd(`REG_CTRL, 32'h1, 32'h3);
		end
		rd(12'h018, 32'h0, 32'h0);
		go(4'h0, 1);
		rd(`REG_STATUS, 32'h2, 32'hF);
		go(4'h2, 4);
		rd(`REG_BEATS, 32'h4, 32'h7);
		rty_en <= 1'b1;
		go(4'h0, 1);
		rd(`REG_STATUS, 32'h2, 32'hF);
		go(4'h1, 0);
		rd(`REG_STATUS, 32'h4, 32'h4);
		rty_en <= 1'b0;
		go(4'h1, 0);
		rd(`REG_RDATA, rd_word, 32'hFFFFFFFF);
		go(4'h3, 0);
		rd(`REG_RDATA, rd_word, 32'hFFFFFFFF);
		err_en <= 1'b1;
		go(4'h1, 0);
		rd(`REG_STATUS, 32'h18, 32'h38);
		apb(1'b1, `REG_STATUS, 32'h18);
		rd(`REG_STATUS, 32'h0, 32'h18);
		go(4'h4, 1);
		rd(`REG_STATUS, 32'h80, 32'h90);
		go(4'hC, 1);
		rd(`REG_STATUS, 32'h10, 32'h10);
		apb(1'b1, `REG_CTRL, 32'h0);
		go(4'h0, 1);
		rd(`REG_STATUS, 32'h20, 32'h20);
		repeat (4) @(posedge ref_clk);
		give_verdict;
	end
endmodule // tb
`default_nettype wire

// ==== sim/term_partner.sv ====
// system side model that terminates data beats
`default_nettype none
module term_partner (
	// clock, reset and bus state
	input wire logic         ref_clk, rst_n, busy_n,
	// scenario controls
	input wire logic         rty_en, err_en, strap_n,
	input wire logic [1:0]   wt,
	input wire logic [31:0]  rd_word,
	// termination and read data
	output logic             beat_ack_n, late_read_retry_n, bus_error_ack_n,
	output logic [31:0]      data_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] cnt_ff;
	logic       ack_ff, rty_ff, err_ff;
	assign beat_ack_n = !ack_ff;
	assign bus_error_ack_n = !err_ff;
	assign late_read_retry_n = rty_ff ? 1'b0 : strap_n;
	assign data_in = ack_ff ? rd_word : ~rd_word;
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{cnt_ff, ack_ff, rty_ff, err_ff} <= 5'h0;
		end
		else
		begin
			rty_ff <= ack_ff & rty_en;
			ack_ff <= 1'b0;
			err_ff <= 1'b0;
			if (busy_n || ack_ff || err_ff)
				cnt_ff <= wt;
			else if (cnt_ff != 2'h0)
				cnt_ff <= cnt_ff - 2'h1;
			else if (err_en)
				err_ff <= 1'b1;
			else
				ack_ff <= 1'b1;
		end
	end
endmodule // term_partner
`default_nettype wire
